//--- microword_params.svh
// Offsets, field positions and reset values of the microword store block
// What this block does
// - Match level high while switches 8..0 equal buffered next address.
// - A match at end of machine cycle gives a scope pulse, halt or not.
// - Bus enable drives the 16 switch bits onto the bus, open collector.
// - Result selector output is buffered onto the console data display.
// - Switch bits 17 and 16 go to the memory-management option.
// - Basic store holds 256 microwords feeding the microword register.
// - Store outputs wired-OR with expansion inputs for higher addresses.
// - Next base address is modified by basic or expanded branch codes.
// - Bits 56..9 active high; bits 8..0 stored active low, then inverted.
// - Without branching, loaded next address is raw field's complement.
// - Buffered next address changes afterwards only through a microjam.
// - Buffered next address addresses expansion stores and is displayed.
// - Each microword reload copies the outgoing next address to previous.
// - Previous-address register is never cleared asynchronously.
// - Select-immediate lets the immediate field pick a scratch register.
// - Inverted low immediate bit feeds the register file address input.
// - Fetch and immediate mode use immediate selection for the counter.
// - Register 0 picked by immediate field during halt and console work.
// - Select-address-register uses low four address latch bits.
// - Select-destination uses instruction bits 2..0.
// - Select-source uses instruction bits 8..6.
// - Scratch registers take result selector data, drive wired-OR bus.
`ifndef MICROWORD_PARAMS_SVH
`define MICROWORD_PARAMS_SVH

`define OFS_CONTROL 12'h000
`define OFS_SWITCH 12'h004
`define OFS_STATUS 12'h008
`define OFS_NEXT_ADDR 12'h00c
`define OFS_PREV_ADDR 12'h010
`define OFS_STORE_LO 12'h014
`define OFS_STORE_HI 12'h018
`define OFS_STORE_INDEX 12'h01c

`define CTRL_BUS_EN_BIT 0
`define STAT_MATCH_BIT 0
`define STAT_CONFLICT_BIT 1

`define NEXT_ADDR_W 9
`define SWITCH_W 18
`define DATA_W 16
`define REG_ADDR_W 4
`define FIELD_SEL_MSB 16
`define FIELD_SEL_LSB 9
`define INSTR_DEST_LSB 0
`define INSTR_SRC_LSB 6
`define SWITCH_HIGH_LSB 16

`define RST_CONTROL 32'h0000_0000
`define RST_SWITCH 18'h00000
`define RST_ADDR 9'h000
`define RST_DATA 16'h0000

`endif

//--- microword_pkg.sv
// Types shared by the microword store block
package microword_pkg;

    typedef struct packed {
        logic select_source;
        logic select_destination;
        logic select_address_register;
        logic select_immediate;
        logic [3:0] immediate_register_field;
    } reg_select_t;

    typedef struct packed {
        logic [8:0] set;
        logic [8:0] clear;
    } jam_masks_t;

    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_IMMEDIATE,
        SRC_ADDRESS,
        SRC_DEST,
        SRC_SOURCE,
        SRC_CONFLICT
    } addr_source_t;

endpackage

//--- microaddress_modifier.sv
// Branch modification of the raw next-address field
`timescale 1ns/100ps
`default_nettype none
module microaddress_modifier (
    input wire logic [8:0] raw_field_n,
    input wire logic [4:0] basic_branch_code,
    input wire logic [4:1] expanded_branch_code,
    output logic [8:0] next_address
);
    // Branch codes only pull bits true, as the gating in front does
    always_comb begin
        next_address = ~raw_field_n;
        next_address = next_address | {4'h0, basic_branch_code};
        next_address = next_address
            | {4'h0, expanded_branch_code, 1'b0};
    end
endmodule
`default_nettype wire

//--- scratch_pad_file.sv
// Scratch-pad register file with byte writes and gated read bus
`timescale 1ns/100ps
`default_nettype none
module scratch_pad_file #(
    parameter int DEPTH = 16,
    parameter int DATA_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [$clog2(DEPTH)-1:0] address,
    input wire logic write_low,
    input wire logic write_high,
    input wire logic [DATA_W-1:0] write_data,
    input wire logic read_enable,
    output logic [DATA_W-1:0] read_bus
);
    localparam int HALF = DATA_W / 2;
    logic [DATA_W-1:0] cells [DEPTH];
    logic [DATA_W-1:0] next_read_bus;

    if (DATA_W % 2 != 0 || DEPTH < 2) begin : g_check
        $error("scratch_pad_file: unsupported size");
    end

    // Zero when not selected so other wired-OR sources can share the bus
    always_comb begin
        next_read_bus = read_enable ? cells[address] : '0;
    end

    always_ff @(posedge pclk) begin
        if (write_low) begin
            cells[address][HALF-1:0] <= write_data[HALF-1:0];
        end
        if (write_high) begin
            cells[address][DATA_W-1:HALF] <= write_data[DATA_W-1:HALF];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_bus <= '0;
        end else begin
            read_bus <= next_read_bus;
        end
    end
endmodule
`default_nettype wire

//--- microword_store_and_console_match.sv
// Control store, microaddress registers, console match and register select
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "microword_params.svh"
module microword_store_and_console_match #(
    parameter int STORE_DEPTH = 256,
    parameter int WORD_W = 57,
    parameter int PADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic microword_load,
    input wire logic microjam_clock,
    input wire microword_pkg::jam_masks_t microjam_masks,
    input wire logic [4:0] basic_branch_code,
    input wire logic [4:1] expanded_branch_code,
    input wire logic [WORD_W-1:0] expansion_store_bus,
    input wire logic cycle_end,
    input wire logic [15:0] instruction_latch,
    input wire logic [3:0] bus_address_low,
    input wire logic [15:0] result_selector_output,
    input wire logic write_low,
    input wire logic write_high,
    input wire logic read_enable,
    output logic [WORD_W-1:0] microword,
    output logic [8:0] buffered_next_microaddress,
    output logic [8:0] previous_microaddress_latch,
    output logic microaddress_match_level,
    output logic match_scope_pulse,
    output logic [15:0] switch_bus_data,
    output logic [15:0] switch_bus_oe,
    output logic [15:0] display_data,
    output logic [1:0] switch_high_bits,
    output logic [3:0] reg_file_address,
    output logic immediate_low_inverted,
    output logic [15:0] scratch_read_bus
);
    localparam int IDX_W = $clog2(STORE_DEPTH);
    localparam int HI_W = WORD_W - 32;
    localparam int AW = `NEXT_ADDR_W;
    // Idle store drives nothing: upper lines low, active-low address high
    localparam logic [WORD_W-1:0] NEUTRAL_WORD =
        {{(WORD_W-AW){1'b0}}, {AW{1'b1}}};

    if (WORD_W <= 32 || WORD_W > 64 || WORD_W <= `FIELD_SEL_MSB
        || STORE_DEPTH < 2 || STORE_DEPTH > 512
        || PADDR_W < 12) begin : g_check
        $error("microword_store: unsupported parameter values");
    end

    // Basic control store, loaded from the bus
    logic [WORD_W-1:0] store [STORE_DEPTH];
    logic store_we;
    logic [IDX_W-1:0] store_waddr;
    logic [WORD_W-1:0] store_wdata;

    // Software-visible state
    logic [31:0] control;
    logic [`SWITCH_W-1:0] switch_settings;
    logic [31:0] staging_lo;
    logic [HI_W-1:0] staging_hi;
    logic [8:0] store_index;
    logic select_conflict;
    logic [31:0] next_control;
    logic [`SWITCH_W-1:0] next_switch_settings;
    logic [31:0] next_staging_lo;
    logic [HI_W-1:0] next_staging_hi;
    logic [8:0] next_store_index;
    logic next_select_conflict;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // Microsequencing state
    logic [WORD_W-1:0] next_microword;
    logic [8:0] next_previous;
    logic next_match_level;
    logic next_match_pulse;
    logic [WORD_W-1:0] store_word;
    logic [WORD_W-1:0] bus_word;
    logic [8:0] modified_address;
    logic [8:0] current_next;
    logic in_range;

    // Console and register select state
    logic [15:0] next_bus_data;
    logic [15:0] next_bus_oe;
    logic [15:0] next_display;
    logic [1:0] next_switch_high;
    logic [3:0] next_reg_address;
    logic next_imm_low_inv;
    logic sel_fault;
    microword_pkg::reg_select_t sel;
    microword_pkg::addr_source_t source;

    function automatic logic [31:0] merge_bytes(
        input logic [31:0] old_value,
        input logic [31:0] new_value,
        input logic [3:0] strobes
    );
        logic [31:0] result;
        result = old_value;
        for (int i = 0; i < 4; i++) begin
            if (strobes[i]) begin
                result[i*8 +: 8] = new_value[i*8 +: 8];
            end
        end
        return result;
    endfunction

    // APB slave: read data and ready are prepared in the setup cycle
    logic setup_phase;
    logic write_commit;
    logic [31:0] merged;

    always_comb begin
        setup_phase = psel && !penable;
        write_commit = psel && penable && pready && pwrite && !pslverr;
        next_pready = setup_phase;
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        next_control = control;
        next_switch_settings = switch_settings;
        next_staging_lo = staging_lo;
        next_staging_hi = staging_hi;
        next_store_index = store_index;
        store_we = 1'b0;
        store_waddr = '0;
        store_wdata = {staging_hi, staging_lo};
        merged = 32'h0000_0000;
        if (setup_phase) begin
            unique case (paddr[11:0])
                `OFS_CONTROL: next_prdata = control;
                `OFS_SWITCH: next_prdata = 32'(switch_settings);
                `OFS_STATUS: begin
                    next_prdata[`STAT_MATCH_BIT] = microaddress_match_level;
                    next_prdata[`STAT_CONFLICT_BIT] = select_conflict;
                end
                `OFS_NEXT_ADDR: next_prdata = 32'(buffered_next_microaddress);
                `OFS_PREV_ADDR:
                    next_prdata = 32'(previous_microaddress_latch);
                `OFS_STORE_LO: next_prdata = staging_lo;
                `OFS_STORE_HI: next_prdata = 32'(staging_hi);
                `OFS_STORE_INDEX: next_prdata = 32'(store_index);
                default: next_pslverr = 1'b1;
            endcase
            if ((paddr >> 12) != '0) begin
                next_pslverr = 1'b1;
                next_prdata = 32'h0000_0000;
            end
        end
        if (write_commit) begin
            unique case (paddr[11:0])
                `OFS_CONTROL: begin
                    next_control = merge_bytes(control, pwdata, pstrb);
                    next_control[31:1] = 31'h0;
                end
                `OFS_SWITCH: begin
                    merged = merge_bytes(32'(switch_settings), pwdata, pstrb);
                    next_switch_settings = merged[`SWITCH_W-1:0];
                end
                `OFS_STORE_LO:
                    next_staging_lo = merge_bytes(staging_lo, pwdata, pstrb);
                `OFS_STORE_HI: begin
                    merged = merge_bytes(32'(staging_hi), pwdata, pstrb);
                    next_staging_hi = merged[HI_W-1:0];
                end
                `OFS_STORE_INDEX: begin
                    // Out-of-range index is kept but stores nothing
                    next_store_index = pwdata[8:0];
                    store_we = 32'(pwdata[8:0]) < STORE_DEPTH;
                    store_waddr = pwdata[IDX_W-1:0];
                end
                default: merged = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            control <= `RST_CONTROL;
            switch_settings <= `RST_SWITCH;
            staging_lo <= 32'h0000_0000;
            staging_hi <= '0;
            store_index <= `RST_ADDR;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            control <= next_control;
            switch_settings <= next_switch_settings;
            staging_lo <= next_staging_lo;
            staging_hi <= next_staging_hi;
            store_index <= next_store_index;
        end
    end

    always_ff @(posedge pclk) begin
        if (store_we) begin
            store[store_waddr] <= store_wdata;
        end
    end

    // Microword register and next address
    assign current_next = microword[AW-1:0];

    always_comb begin
        in_range = 32'(current_next) < STORE_DEPTH;
        // Above the basic range only the expansion stores answer
        store_word = in_range ? store[current_next[IDX_W-1:0]]
                              : NEUTRAL_WORD;
        bus_word[WORD_W-1:AW] = store_word[WORD_W-1:AW]
            | expansion_store_bus[WORD_W-1:AW];
        bus_word[AW-1:0] = store_word[AW-1:0]
            & expansion_store_bus[AW-1:0];
    end

    microaddress_modifier microaddress_modifier_i (
        .raw_field_n(bus_word[AW-1:0]),
        .basic_branch_code(basic_branch_code),
        .expanded_branch_code(expanded_branch_code),
        .next_address(modified_address)
    );

    always_comb begin
        next_microword = microword;
        next_previous = previous_microaddress_latch;
        if (microword_load) begin
            next_microword = {bus_word[WORD_W-1:AW],
                              modified_address};
            next_previous = current_next;
        end
        // A jam acts on top of a load in the same cycle
        if (microjam_clock) begin
            next_microword[AW-1:0] = (next_microword[AW-1:0]
                | microjam_masks.set)
                & ~microjam_masks.clear;
        end
        next_match_level = next_microword[AW-1:0]
            == switch_settings[AW-1:0];
        next_match_pulse = cycle_end && microaddress_match_level;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            microword <= NEUTRAL_WORD ^ {{(WORD_W-AW){1'b0}}, {AW{1'b1}}};
            microaddress_match_level <= 1'b0;
            match_scope_pulse <= 1'b0;
        end else begin
            microword <= next_microword;
            microaddress_match_level <= next_match_level;
            match_scope_pulse <= next_match_pulse;
        end
    end

    // No asynchronous clear here; reset acts only with the clock
    always_ff @(posedge pclk) begin
        if (!presetn) begin
            previous_microaddress_latch <= `RST_ADDR;
        end else begin
            previous_microaddress_latch <= next_previous;
        end
    end

    // Same flops feed the console display and the expansion stores
    assign buffered_next_microaddress = current_next;

    // Console gating
    always_comb begin
        next_bus_oe = control[`CTRL_BUS_EN_BIT]
            ? switch_settings[`DATA_W-1:0] : 16'h0000;
        // Open collector: a line is pulled low wherever it is driven
        next_bus_data = ~next_bus_oe;
        next_display = result_selector_output;
        next_switch_high = switch_settings[`SWITCH_W-1:`SWITCH_HIGH_LSB];
    end

    // Register file address source
    always_comb begin
        sel = microword_pkg::reg_select_t'(
            microword[`FIELD_SEL_MSB:`FIELD_SEL_LSB]);
        sel_fault = 1'b0;
        unique case ({sel.select_source, sel.select_destination, sel.select_address_register, sel.select_immediate})
            4'h0: source = microword_pkg::SRC_NONE;
            4'h1: source = microword_pkg::SRC_IMMEDIATE;
            4'h2: source = microword_pkg::SRC_ADDRESS;
            4'h4: source = microword_pkg::SRC_DEST;
            4'h8: source = microword_pkg::SRC_SOURCE;
            default: begin
                source = microword_pkg::SRC_CONFLICT;
                sel_fault = 1'b1;
            end
        endcase
        next_reg_address = 4'h0;
        unique case (source)
            microword_pkg::SRC_NONE: next_reg_address = 4'h0;
            // Program counter, stack pointer or register 0 by immediate
            microword_pkg::SRC_IMMEDIATE:
                next_reg_address = sel.immediate_register_field;
            microword_pkg::SRC_ADDRESS:
                next_reg_address = bus_address_low;
            microword_pkg::SRC_DEST:
                next_reg_address = {1'b0,
                    instruction_latch[`INSTR_DEST_LSB +: 3]};
            microword_pkg::SRC_SOURCE:
                next_reg_address = {1'b0,
                    instruction_latch[`INSTR_SRC_LSB +: 3]};
            microword_pkg::SRC_CONFLICT: next_reg_address = 4'h0;
        endcase
        next_imm_low_inv = ~sel.immediate_register_field[0];
        // Sticky; a new fault wins over a clear in the same cycle
        next_select_conflict = select_conflict;
        if (write_commit && paddr[11:0] == `OFS_STATUS && pstrb[0]
            && pwdata[`STAT_CONFLICT_BIT]) begin
            next_select_conflict = 1'b0;
        end
        if (sel_fault) begin
            next_select_conflict = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_bus_data <= 16'hffff;
            switch_bus_oe <= 16'h0000;
            display_data <= `RST_DATA;
            switch_high_bits <= 2'h0;
            reg_file_address <= 4'h0;
            immediate_low_inverted <= 1'b1;
            select_conflict <= 1'b0;
        end else begin
            switch_bus_data <= next_bus_data;
            switch_bus_oe <= next_bus_oe;
            display_data <= next_display;
            switch_high_bits <= next_switch_high;
            reg_file_address <= next_reg_address;
            immediate_low_inverted <= next_imm_low_inv;
            select_conflict <= next_select_conflict;
        end
    end

    scratch_pad_file #(
        .DEPTH(16),
        .DATA_W(`DATA_W)
    ) scratch_pad_file_i (
        .pclk(pclk),
        .presetn(presetn),
        .address(reg_file_address),
        .write_low(write_low),
        .write_high(write_high),
        .write_data(result_selector_output),
        .read_enable(read_enable),
        .read_bus(scratch_read_bus)
    );
endmodule
`default_nettype wire

//--- microword_checker_sva.sv
// Port-level assertions for the microword store block
`timescale 1ns/100ps
`default_nettype none
module microword_checker #(
    parameter int WORD_W = 57
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic microword_load,
    input wire logic microjam_clock,
    input wire logic cycle_end,
    input wire logic [15:0] instruction_latch,
    input wire logic [WORD_W-1:0] microword,
    input wire logic [8:0] buffered_next_microaddress,
    input wire logic [8:0] previous_microaddress_latch,
    input wire logic microaddress_match_level,
    input wire logic match_scope_pulse,
    input wire logic [15:0] switch_bus_data,
    input wire logic [15:0] switch_bus_oe,
    input wire logic [3:0] reg_file_address,
    input wire logic immediate_low_inverted
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    hold_addr_a: assert property (
        !microword_load && !microjam_clock |=>
        $stable(buffered_next_microaddress))
        else $error("next address moved without load or jam");
    prev_capture_a: assert property (microword_load |=>
        previous_microaddress_latch == $past(buffered_next_microaddress))
        else $error("previous address not captured");
    scope_pulse_a: assert property (1'b1 |=> match_scope_pulse ==
        ($past(cycle_end) && $past(microaddress_match_level)))
        else $error("scope pulse wrong");
    open_drain_a: assert property (
        switch_bus_data == ~switch_bus_oe)
        else $error("bus driver data not inverse of enable");
    imm_low_a: assert property (microword[16:13] == 4'h1 |=>
        immediate_low_inverted == !$past(microword[9]))
        else $error("inverted low immediate bit wrong");
    sel_imm_a: assert property (microword[16:13] == 4'h1 |=>
        reg_file_address == $past(microword[12:9]))
        else $error("immediate select wrong");
    sel_src_a: assert property (microword[16:13] == 4'h8 |=>
        reg_file_address == {1'b0, $past(instruction_latch[8:6])})
        else $error("source select wrong");
    sel_dst_a: assert property (microword[16:13] == 4'h4 |=>
        reg_file_address == {1'b0, $past(instruction_latch[2:0])})
        else $error("destination select wrong");
    sel_many_a: assert property (
        $countones(microword[16:13]) > 1 |=> reg_file_address == 4'h0)
        else $error("several selects did not give register 0");
    cover property (match_scope_pulse);
    cover property (microjam_clock);
    cover property ($countones(microword[16:13]) > 1);
endmodule
bind microword_store_and_console_match microword_checker
    #(.WORD_W(WORD_W)) microword_checker_i (.*);
`default_nettype wire

//--- console_panel_model.sv
// Console panel and expansion store stand-in for the microword block
`timescale 1ns/100ps
`default_nettype none
module console_panel_model (
    input wire logic [8:0] buffered_next_microaddress,
    input wire logic [56:0] exp_word,
    input wire logic [15:0] switch_bus_oe,
    input wire logic microaddress_match_level,
    input wire logic slow_prev,
    output logic [56:0] expansion_store_bus,
    output logic [15:0] bus_level,
    output logic halt_request
);
    localparam logic [8:0] exp_base = 9'h100;
    // Unselected store leaves the terminated lines at idle
    assign expansion_store_bus = buffered_next_microaddress == exp_base
        ? {exp_word[56:9], ~exp_word[8:0]}
        : {48'h0, 9'h1ff};
    // Pull-ups hold a line high unless a driver sinks it
    assign bus_level = ~switch_bus_oe;
    // Halt only trusted after a slow-class microword
    assign halt_request = microaddress_match_level & slow_prev;
endmodule
`default_nettype wire

//--- microword_store_and_console_match_tb.sv
// Self-checking bench for the microword store block
`timescale 1ns/100ps
`default_nettype none
module microword_store_and_console_match_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hf, bus_address_low = 4'h0, reg_file_address;
    logic microword_load = 1'b0, microjam_clock = 1'b0, cycle_end = 1'b0;
    microword_pkg::jam_masks_t microjam_masks = 18'h0;
    logic [4:0] basic_branch_code = 5'h00;
    logic [4:1] expanded_branch_code = 4'h0;
    logic [56:0] expansion_store_bus, microword, exp_word = 57'h0;
    logic [15:0] instruction_latch = 16'h0, result_selector_output = 16'h0;
    logic write_low = 1'b0, write_high = 1'b0, read_enable = 1'b0;
    logic [8:0] buffered_next_microaddress, previous_microaddress_latch;
    logic microaddress_match_level, match_scope_pulse, immediate_low_inverted;
    logic [15:0] switch_bus_data, switch_bus_oe, display_data;
    logic [15:0] scratch_read_bus, bus_level;
    logic [1:0] switch_high_bits;
    logic halt_request, slow_prev = 1'b1;
    int error_cnt = 0, num_checks = 0;
    microword_store_and_console_match
        microword_store_and_console_match_i (.*);
    console_panel_model console_panel_model_i (.*);
    always #25 pclk = ~pclk;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic store_word(input logic [8:0] i, input logic [56:0] w);
        apb(1'b1, 12'h014, w[31:0]);
        apb(1'b1, 12'h018, {7'h00, w[56:32]});
        apb(1'b1, 12'h01c, {23'h0, i});
    endtask
    task automatic load(input logic [4:0] b, input logic [4:1] e,
            input logic [56:0] w);
        @(posedge pclk);
        microword_load <= 1'b1;
        basic_branch_code <= b;
        expanded_branch_code <= e;
        exp_word <= w;
        @(posedge pclk);
        microword_load <= 1'b0;
        basic_branch_code <= 5'h00;
        expanded_branch_code <= 4'h0;
        @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic jam(input logic [8:0] s, input logic [8:0] c);
        @(posedge pclk);
        microjam_clock <= 1'b1;
        microjam_masks <= {s, c};
        @(posedge pclk);
        microjam_clock <= 1'b0;
        @(negedge pclk);
    endtask
    task automatic t_flow();
        store_word(9'h000, {1'b1, 42'h0, 14'h2ffa});
        store_word(9'h005, {40'h0, 17'h101ef});
        instruction_latch <= 16'h0183;
        load(5'h00, 4'h0, 57'h0);
        chk(microword, {1'b1, 42'h0, 14'h2e05});
        chk(buffered_next_microaddress, 9'h005);
        chk(reg_file_address, 4'h7);
        chk(immediate_low_inverted, 1'b0);
        load(5'h03, 4'h0, 57'h0);
        chk(buffered_next_microaddress, 9'h013);
        chk(previous_microaddress_latch, 9'h005);
        chk(reg_file_address, 4'h6);
        jam(9'h100, 9'h013);
        chk(buffered_next_microaddress, 9'h100);
        // Expansion word arrives only through the wired-OR lines
        load(5'h00, 4'h1, {41'h0, 16'h8005});
        chk(microword, {41'h0, 16'h8007});
        chk(previous_microaddress_latch, 9'h100);
        chk(reg_file_address, 4'h3);
    endtask
    task automatic t_match();
        apb(1'b1, 12'h004, 32'h0003_0007);
        @(posedge pclk);
        cycle_end <= 1'b1;
        @(posedge pclk);
        cycle_end <= 1'b0;
        @(negedge pclk);
        chk(microaddress_match_level, 1'b1);
        chk(match_scope_pulse, 1'b1);
        chk(switch_high_bits, 2'h3);
        chk(halt_request, 1'b1);
        slow_prev <= 1'b0;
        @(posedge pclk);
        @(negedge pclk);
        chk(halt_request, 1'b0);
        apb(1'b1, 12'h004, 32'h0000_0006);
        @(posedge pclk);
        @(negedge pclk);
        chk(microaddress_match_level, 1'b0);
    endtask
    task automatic t_console();
        apb(1'b1, 12'h000, 32'h0000_0001);
        apb(1'b1, 12'h004, 32'h0000_a5c3);
        result_selector_output <= 16'h1234;
        bus_address_low <= 4'h9;
        @(posedge pclk);
        @(negedge pclk);
        chk(switch_bus_oe, 16'ha5c3);
        chk(bus_level, 16'h5a3c);
        chk(display_data, 16'h1234);
    endtask
    task automatic t_scratch();
        @(posedge pclk);
        result_selector_output <= 16'hbeef;
        write_low <= 1'b1;
        write_high <= 1'b1;
        @(posedge pclk);
        write_low <= 1'b0;
        write_high <= 1'b0;
        read_enable <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        chk(scratch_read_bus, 16'hbeef);
    endtask
    task automatic t_conflict();
        jam(9'h100, 9'h007);
        load(5'h00, 4'h0, {42'h0, 15'h4005});
        chk(reg_file_address, 4'h9);
        jam(9'h100, 9'h005);
        load(5'h00, 4'h0, {40'h0, 17'h18005});
        chk(reg_file_address, 4'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd[1], 1'b1);
        chk({err, rd[0]}, 2'h0);
    endtask
    task automatic print_verdict();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_flow();
        t_match();
        t_console();
        t_scratch();
        t_conflict();
        print_verdict();
    end
    // Run needs under a hundred cycles; margin only catches a hang
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
endmodule
`default_nettype wire
